// ==== hw/rpc_pkg.sv ====
package rpc_pkg;

    localparam int unsigned RPC_NREGS = 14;

    localparam logic [7:0] RPC_OFS_SIGNAL_DETECT_THRESHOLD    = 8'h22;
    localparam logic [7:0] RPC_OFS_SYMBOL_TIMING_RECOVERY_CFG = 8'h23;
    localparam logic [7:0] RPC_OFS_GAIN_CONTROL_MEASURE_CFG   = 8'h24;
    localparam logic [7:0] RPC_OFS_GAIN_CONTROL_THRESHOLDS    = 8'h25;
    localparam logic [7:0] RPC_OFS_GAIN_CONTROL_ENABLE        = 8'h26;
    localparam logic [7:0] RPC_OFS_ANTENNA_AND_BLANKING_CFG   = 8'h27;
    localparam logic [7:0] RPC_OFS_FRAME_FIELD_LENGTHS        = 8'h30;
    localparam logic [7:0] RPC_OFS_FRAME_FORMAT_CFG           = 8'h31;
    localparam logic [7:0] RPC_OFS_PREAMBLE_SYNC_LENGTH_CFG   = 8'h32;
    localparam logic [7:0] RPC_OFS_CHECKSUM_CODING_CFG        = 8'h33;
    localparam logic [7:0] RPC_OFS_FRAME_LENGTH_HIGH          = 8'h34;
    localparam logic [7:0] RPC_OFS_FRAME_LENGTH_LOW           = 8'h35;
    localparam logic [7:0] RPC_OFS_SYNC_PATTERN_BYTE_4        = 8'h36;
    localparam logic [7:0] RPC_OFS_SYNC_PATTERN_BYTE_3        = 8'h37;

    // Offsets, index 0 is signal_detect_threshold
    localparam logic [RPC_NREGS-1:0][7:0] RPC_OFS = {
        RPC_OFS_SYNC_PATTERN_BYTE_3, RPC_OFS_SYNC_PATTERN_BYTE_4,
        RPC_OFS_FRAME_LENGTH_LOW, RPC_OFS_FRAME_LENGTH_HIGH,
        RPC_OFS_CHECKSUM_CODING_CFG, RPC_OFS_PREAMBLE_SYNC_LENGTH_CFG,
        RPC_OFS_FRAME_FORMAT_CFG, RPC_OFS_FRAME_FIELD_LENGTHS,
        RPC_OFS_ANTENNA_AND_BLANKING_CFG, RPC_OFS_GAIN_CONTROL_ENABLE,
        RPC_OFS_GAIN_CONTROL_THRESHOLDS, RPC_OFS_GAIN_CONTROL_MEASURE_CFG,
        RPC_OFS_SYMBOL_TIMING_RECOVERY_CFG, RPC_OFS_SIGNAL_DETECT_THRESHOLD};

    // Reset values in the same order
    localparam logic [RPC_NREGS-1:0][7:0] RPC_RST = {
        8'h88, 8'h88, 8'h14, 8'h00, 8'h20, 8'h1E, 8'h07,
        8'h00, 8'h05, 8'h8A, 8'h65, 8'h22, 8'h58, 8'h24};

    // Writable bits; the rest are reserved and hold their reset value
    localparam logic [RPC_NREGS-1:0][7:0] RPC_WMASK = {
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFD, 8'hFF, 8'hFF,
        8'h1F, 8'h1F, 8'h80, 8'hFF, 8'h0F, 8'hFF, 8'hFF};

    localparam int unsigned RPC_IX_SDT  = 0;
    localparam int unsigned RPC_IX_STR  = 1;
    localparam int unsigned RPC_IX_GCM  = 2;
    localparam int unsigned RPC_IX_GCT  = 3;
    localparam int unsigned RPC_IX_GCE  = 4;
    localparam int unsigned RPC_IX_ANT  = 5;
    localparam int unsigned RPC_IX_FFL  = 6;
    localparam int unsigned RPC_IX_FMT  = 7;
    localparam int unsigned RPC_IX_PSL  = 8;
    localparam int unsigned RPC_IX_CHK  = 9;
    localparam int unsigned RPC_IX_LENH = 10;
    localparam int unsigned RPC_IX_LENL = 11;
    localparam int unsigned RPC_IX_SY4  = 12;
    localparam int unsigned RPC_IX_SY3  = 13;

    localparam logic [4:0] RPC_POSTFILTER_SHORT = 5'h08;
    localparam logic [4:0] RPC_POSTFILTER_LONG  = 5'h10;

    localparam logic [23:0] RPC_CRC_POLY_1 = 24'h000007;
    localparam logic [23:0] RPC_CRC_POLY_2 = 24'h008005;
    localparam logic [23:0] RPC_CRC_POLY_3 = 24'h001021;
    localparam logic [23:0] RPC_CRC_POLY_4 = 24'h864CBF;

    typedef enum logic [1:0] {RPC_FMT_BASIC, RPC_FMT_RSVD, RPC_FMT_METER_BUS, RPC_FMT_LINK_LAYER} rpc_format_e;
    typedef enum logic [1:0] {RPC_RX_NORMAL, RPC_RX_VIA_BUFFER, RPC_RX_VIA_PIN, RPC_RX_RSVD} rpc_rx_path_e;
    typedef enum logic [1:0] {RPC_TX_NORMAL, RPC_TX_FROM_BUFFER, RPC_TX_FROM_PIN, RPC_TX_PN9} rpc_tx_src_e;

    typedef struct packed {
        logic [7:0] signal_detect_level;
        logic [7:0] timing_loop_prop_gain;
        logic [4:0] timing_postfilter_span;
        logic [3:0] timing_loop_integral_gain;
        logic [3:0] gain_measure_time;
        logic [3:0] gain_thr_high;
        logic [3:0] gain_thr_low;
        logic       auto_gain_on;
        logic       weak_signal_suppress;
        logic       antenna_switch_on;
        logic [2:0] antenna_switch_dwell;
    } rpc_rx_cfg_s;

    typedef struct packed {
        logic [1:0]  addr_field_bytes;
        logic        link_layer_addr;
        logic [2:0]  ctrl_field_bytes;
        rpc_format_e frame_format_sel;
        rpc_rx_path_e rx_path_sel;
        logic [3:0]  length_field_bits;
        logic [5:0]  preamble_bytes;
        logic [2:0]  sync_bytes;
        logic        length_mode_sel;
        logic [23:0] crc_poly;
        logic        crc_on;
        logic        scrambler_on;
        rpc_tx_src_e transmit_source_sel;
        logic        error_coding_on;
        logic [15:0] frame_length;
        logic [15:0] sync_upper;
    } rpc_pkt_cfg_s;

endpackage : rpc_pkg

// ==== hw/rpc_regs.sv ====
`timescale 1ns/1ps
// Contract
// - Signal-detect threshold in 0.5 dB steps, 0x14 is -120 dBm; compared to RSSI.
// - Clock recovery proportional gain field is log2 of loop gain.
// - Post-filter length 8 symbols when bit clear, 16 when set.
// - Integral gain applies only in phase-locked loop recovery mode.
// - Gain control upper threshold bits 7:4, lower threshold bits 3:0.
// - Blanking set: no receive buffer writes while below carrier-sense threshold.
// - Antenna switching only when enabled, dwell from 3-bit field.
// - Address length 2 bits; 0 or 1 basic, 2 link-layer format.
// - Control field length in bytes from 3-bit field.
// - Frame format: 0 basic, 2 meter-bus, 3 link-layer.
// - Receive path: 0 packet handling, 1 via buffer, 2 via pin.
// - Length field width in bits from 4-bit field.
// - Preamble of 1 to 32 bytes from 5-bit field.
// - Sync field of 1 to 4 bytes from 2-bit field.
// - Length mode 0 fixed, 1 variable; host sets width first.
// - CRC code 0 none, 1..4 polynomials 0x07, 0x8005, 0x1021, 0x864CBF.
// - Whitening on transmit and de-whitening on receive when enabled.
// - Transmit source: normal, from buffer, from pin, PN9.
// - FEC enable: encode on transmit, Viterbi decode on receive.
// - Frame length from high and low bytes, low resets to 0x14.
module rpc_regs
    import rpc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         cfg_wr,
    input  wire logic         cfg_rd,
    input  wire logic [7:0]   cfg_addr,
    input  wire logic [7:0]   cfg_wdata,
    output logic      [7:0]   cfg_rdata,
    output logic              cfg_rvalid,
    input  wire logic [7:0]   rssi_level,
    input  wire logic         timing_pll_mode,
    input  wire logic         carrier_sensed,
    input  wire logic         rx_byte_valid,
    output logic              signal_detected,
    output logic              rx_buffer_write,
    output rpc_rx_cfg_s       rx_cfg,
    output rpc_pkt_cfg_s      pkt_cfg
);

    typedef struct packed {
        logic [RPC_NREGS-1:0][7:0] regs;
        logic [7:0]                rdata;
        logic                      rvalid;
        logic                      detected;
        logic                      rx_write;
        rpc_rx_cfg_s               rx;
        rpc_pkt_cfg_s              pkt;
    } rpc_state_s;

    rpc_state_s st_q;
    rpc_state_s st_d;

    function automatic logic [23:0] rpc_crc_poly(input logic [2:0] code);
        logic [23:0] p;
        p = 24'h000000;
        case (code)
            3'h1:    p = RPC_CRC_POLY_1;
            3'h2:    p = RPC_CRC_POLY_2;
            3'h3:    p = RPC_CRC_POLY_3;
            3'h4:    p = RPC_CRC_POLY_4;
            default: p = 24'h000000;
        endcase
        return p;
    endfunction : rpc_crc_poly

    always_comb
    begin
        logic [RPC_NREGS-1:0][7:0] r;
        logic [7:0]                rd;
        r  = st_q.regs;
        rd = 8'h00;
        st_d = st_q;
        for (int i = 0; i < RPC_NREGS; i++)
        begin
            if (cfg_wr && cfg_addr == RPC_OFS[i])
            begin
                r[i] = (cfg_wdata & RPC_WMASK[i]) | (RPC_RST[i] & ~RPC_WMASK[i]);
            end
            if (cfg_addr == RPC_OFS[i])
            begin
                rd = st_q.regs[i];
            end
        end
        st_d.regs   = r;
        st_d.rvalid = cfg_rd;
        st_d.rdata  = cfg_rd ? rd : 8'h00;

        // Receiver digital settings
        st_d.rx.signal_detect_level = r[RPC_IX_SDT];
        st_d.detected = rssi_level >= st_q.rx.signal_detect_level;
        st_d.rx.timing_loop_prop_gain = 8'h01 << r[RPC_IX_STR][7:5];
        st_d.rx.timing_postfilter_span = r[RPC_IX_STR][4] ? RPC_POSTFILTER_LONG : RPC_POSTFILTER_SHORT;
        st_d.rx.timing_loop_integral_gain = timing_pll_mode ? r[RPC_IX_STR][3:0] : 4'h0;
        st_d.rx.gain_measure_time = r[RPC_IX_GCM][3:0];
        st_d.rx.gain_thr_high = r[RPC_IX_GCT][7:4];
        st_d.rx.gain_thr_low  = r[RPC_IX_GCT][3:0];
        st_d.rx.auto_gain_on  = r[RPC_IX_GCE][7];
        st_d.rx.weak_signal_suppress = r[RPC_IX_ANT][4];
        st_d.rx_write = rx_byte_valid && !(st_q.rx.weak_signal_suppress && !carrier_sensed);
        st_d.rx.antenna_switch_on = r[RPC_IX_ANT][3];
        st_d.rx.antenna_switch_dwell = r[RPC_IX_ANT][3] ? r[RPC_IX_ANT][2:0] : 3'h0;

        // Packet handler settings
        st_d.pkt.addr_field_bytes = r[RPC_IX_FFL][4:3];
        st_d.pkt.link_layer_addr  = r[RPC_IX_FFL][4:3] == 2'h2;
        st_d.pkt.ctrl_field_bytes = r[RPC_IX_FFL][2:0];
        st_d.pkt.frame_format_sel = rpc_format_e'(r[RPC_IX_FMT][7:6]);
        st_d.pkt.rx_path_sel = rpc_rx_path_e'(r[RPC_IX_FMT][5:4]);
        st_d.pkt.length_field_bits = r[RPC_IX_FMT][3:0];
        st_d.pkt.preamble_bytes = {1'b0, r[RPC_IX_PSL][7:3]} + 6'h01;
        st_d.pkt.sync_bytes = {1'b0, r[RPC_IX_PSL][2:1]} + 3'h1;
        st_d.pkt.length_mode_sel = r[RPC_IX_PSL][0];
        st_d.pkt.crc_poly = rpc_crc_poly(r[RPC_IX_CHK][7:5]);
        st_d.pkt.crc_on = r[RPC_IX_CHK][7:5] != 3'h0;
        st_d.pkt.scrambler_on = r[RPC_IX_CHK][4];
        st_d.pkt.transmit_source_sel = rpc_tx_src_e'(r[RPC_IX_CHK][3:2]);
        st_d.pkt.error_coding_on = r[RPC_IX_CHK][0];
        st_d.pkt.frame_length = {r[RPC_IX_LENH], r[RPC_IX_LENL]};
        st_d.pkt.sync_upper = {r[RPC_IX_SY4], r[RPC_IX_SY3]};
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
            st_q.regs <= RPC_RST;
            st_q.rx.signal_detect_level <= RPC_RST[RPC_IX_SDT];
            st_q.rx.timing_loop_prop_gain <= 8'h04;
            st_q.rx.timing_postfilter_span <= RPC_POSTFILTER_LONG;
            st_q.rx.gain_measure_time <= 4'h2;
            st_q.rx.gain_thr_high <= 4'h6;
            st_q.rx.gain_thr_low <= 4'h5;
            st_q.rx.auto_gain_on <= 1'b1;
            st_q.pkt.length_field_bits <= 4'h7;
            st_q.pkt.preamble_bytes <= 6'h04;
            st_q.pkt.sync_bytes <= 3'h4;
            st_q.pkt.crc_poly <= RPC_CRC_POLY_1;
            st_q.pkt.crc_on <= 1'b1;
            st_q.pkt.frame_length <= {RPC_RST[RPC_IX_LENH], RPC_RST[RPC_IX_LENL]};
            st_q.pkt.sync_upper <= {RPC_RST[RPC_IX_SY4], RPC_RST[RPC_IX_SY3]};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign cfg_rdata       = st_q.rdata;
    assign cfg_rvalid      = st_q.rvalid;
    assign signal_detected = st_q.detected;
    assign rx_buffer_write = st_q.rx_write;
    assign rx_cfg          = st_q.rx;
    assign pkt_cfg         = st_q.pkt;

endmodule : rpc_regs

// ==== bench/rpc_host.sv ====
`timescale 1ns/1ps
module rpc_host (
    input  logic       clk,
    output logic       cfg_wr,
    output logic       cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [7:0] cfg_wdata
);
    initial {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = 18'h0;
    // One strobe cycle, then address and data inverted
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {w, !w, a, d};
        @(negedge clk);
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'h0, ~a, ~d};
    endtask : acc
    // Width before variable length
    task automatic var_len(input logic [7:0] fmt);
        acc(1'b1, 8'h31, fmt);
        acc(1'b1, 8'h32, 8'h1F);
    endtask : var_len
endmodule : rpc_host

// ==== bench/rpc_regs_sva.sv ====
`timescale 1ns/1ps
module rpc_regs_sva
    import rpc_pkg::*;
(
    input logic         clk,
    input logic         sys_rst,
    input logic         cfg_wr,
    input logic         cfg_rd,
    input logic [7:0]   cfg_addr,
    input logic [7:0]   cfg_wdata,
    input logic [7:0]   cfg_rdata,
    input logic         cfg_rvalid,
    input logic [7:0]   rssi_level,
    input logic         timing_pll_mode,
    input logic         carrier_sensed,
    input logic         rx_byte_valid,
    input logic         signal_detected,
    input logic         rx_buffer_write,
    input rpc_rx_cfg_s  rx_cfg,
    input rpc_pkt_cfg_s pkt_cfg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    read_answer_a: assert property (cfg_rvalid == $past(cfg_rd && !sys_rst))
        else $error("read answer timing wrong");
    idle_rdata_a: assert property (!cfg_rvalid |-> cfg_rdata == 8'h00)
        else $error("read data not zero when idle");
    len_low_a: assert property (cfg_wr && cfg_addr == 8'h35 |=> pkt_cfg.frame_length[7:0] == $past(cfg_wdata))
        else $error("length low byte not taken");
    reserved_read_a: assert property (cfg_rd && cfg_addr == 8'h24 |=> cfg_rdata[7:4] == 4'h2)
        else $error("reserved bits changed");
    blank_gate_a: assert property (rx_buffer_write ==
        $past(rx_byte_valid && (carrier_sensed || !rx_cfg.weak_signal_suppress)))
        else $error("buffer write gating wrong");
    detect_level_a: assert property (signal_detected == $past(rssi_level >= rx_cfg.signal_detect_level))
        else $error("signal detect wrong");
    integral_gate_a: assert property (!timing_pll_mode [*2] |-> rx_cfg.timing_loop_integral_gain == 4'h0)
        else $error("integral gain outside loop mode");
    dwell_off_a: assert property (!rx_cfg.antenna_switch_on |-> rx_cfg.antenna_switch_dwell == 3'h0)
        else $error("dwell while switching off");
    preamble_len_a: assert property (cfg_wr && cfg_addr == 8'h32 |=>
        pkt_cfg.preamble_bytes == {1'b0, $past(cfg_wdata[7:3])} + 6'h01)
        else $error("preamble length wrong");
    crc_code_a: assert property (cfg_wr && cfg_addr == 8'h33 && cfg_wdata[7:5] == 3'h2 |=>
        pkt_cfg.crc_poly == 24'h008005)
        else $error("crc polynomial wrong");
    cover property (cfg_rvalid);
    cover property (rx_byte_valid && !carrier_sensed && rx_cfg.weak_signal_suppress);
    cover property (signal_detected);
endmodule : rpc_regs_sva

// ==== bench/rpc_regs_tb_top.sv ====
`timescale 1ns/1ps
module rpc_regs_tb_top;
    import rpc_pkg::*;
    logic         clk, sys_rst, cfg_wr, cfg_rd, cfg_rvalid, pll, cs, rxv, sdet, rxw;
    logic [7:0]   cfg_addr, cfg_wdata, cfg_rdata, rssi, d;
    rpc_rx_cfg_s  rx_cfg;
    rpc_pkt_cfg_s pkt_cfg;
    int           n_mismatch = 0;
    int           cmp_count = 0;
    logic [7:0]   exp_q[$];
    logic [24:0]  crc_tab [5] = '{25'h0, {1'b1, RPC_CRC_POLY_1}, {1'b1, RPC_CRC_POLY_2},
                                  {1'b1, RPC_CRC_POLY_3}, {1'b1, RPC_CRC_POLY_4}};
    rpc_host host_u (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
    rpc_regs dut_u (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .rssi_level(rssi),
        .timing_pll_mode(pll), .carrier_sensed(cs), .rx_byte_valid(rxv), .signal_detected(sdet),
        .rx_buffer_write(rxw), .rx_cfg(rx_cfg), .pkt_cfg(pkt_cfg));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.acc(1'b0, a, 8'h00);
    endtask : rd
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Read results against the oldest note
    always @(negedge clk)
        if (cfg_rvalid === 1'b1)
            chk("read data", exp_q.pop_front(), cfg_rdata);
    initial
    begin
        #(100 * 3000);
        n_mismatch++;
        test_done();
    end
    initial
    begin
        {sys_rst, pll, cs, rxv, rssi} = {1'b1, 11'h000};
        void'($urandom(88));
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < RPC_NREGS; i++)
            rd(RPC_OFS[i], RPC_RST[i]);
        rd(8'h28, 8'h00);
        chk("reset decode", 32'h0410, 32'({rx_cfg.timing_loop_prop_gain, 3'h0, rx_cfg.timing_postfilter_span}));
        chk("reset frame", 32'h00148888, {pkt_cfg.frame_length, pkt_cfg.sync_upper});
        $display("test reset values done");
        for (int i = 0; i < RPC_NREGS; i++)
        begin
            d = 8'($urandom);
            pll = 1'($urandom);
            host_u.acc(1'b1, RPC_OFS[i], d);
            rd(RPC_OFS[i], (d & RPC_WMASK[i]) | (RPC_RST[i] & ~RPC_WMASK[i]));
        end
        host_u.acc(1'b1, 8'h28, 8'hFF);
        rd(8'h28, 8'h00);
        $display("test random access done");
        host_u.acc(1'b1, 8'h34, 8'h01);
        host_u.acc(1'b1, 8'h35, 8'hFF);
        host_u.var_len(8'hC9);
        @(negedge clk);
        chk("length", 32'h1FF, 32'(pkt_cfg.frame_length));
        chk("mode", 32'h19, 32'({pkt_cfg.length_mode_sel, pkt_cfg.length_field_bits}));
        chk("format", 32'(RPC_FMT_LINK_LAYER), 32'(pkt_cfg.frame_format_sel));
        chk("pre sync", 32'h24, 32'({pkt_cfg.preamble_bytes, pkt_cfg.sync_bytes}));
        $display("test frame layout done");
        for (int c = 0; c < 5; c++)
        begin
            host_u.acc(1'b1, 8'h33, 8'((c << 5) | ((c & 2) << 3) | ((c & 3) << 2) | (c & 1)));
            @(negedge clk);
            chk("crc", 32'(crc_tab[c]), 32'({pkt_cfg.crc_on, pkt_cfg.crc_poly}));
            chk("coding", 32'({c[1], c[1:0], c[0]}), 32'({pkt_cfg.scrambler_on,
                pkt_cfg.transmit_source_sel, pkt_cfg.error_coding_on}));
        end
        $display("test checksum coding done");
        pll = 1'b1;
        host_u.acc(1'b1, 8'h23, 8'hA7);
        host_u.acc(1'b1, 8'h24, 8'hF3);
        host_u.acc(1'b1, 8'h25, 8'h9C);
        host_u.acc(1'b1, 8'h26, 8'h00);
        host_u.acc(1'b1, 8'h27, 8'h0E);
        host_u.acc(1'b1, 8'h30, 8'h15);
        host_u.acc(1'b1, 8'h31, 8'hA0);
        host_u.acc(1'b1, 8'h33, 8'hE0);
        host_u.acc(1'b1, 8'h36, 8'h5A);
        host_u.acc(1'b1, 8'h37, 8'hC3);
        @(negedge clk);
        chk("prop gain", 32'h20, 32'(rx_cfg.timing_loop_prop_gain));
        chk("postfilter", 32'(RPC_POSTFILTER_SHORT), 32'(rx_cfg.timing_postfilter_span));
        chk("integral", 32'h7, 32'(rx_cfg.timing_loop_integral_gain));
        chk("agc", 32'h9C3, 32'({rx_cfg.gain_thr_high, rx_cfg.gain_thr_low, rx_cfg.gain_measure_time}));
        chk("agc on", 32'h0, 32'(rx_cfg.auto_gain_on));
        chk("antenna", 32'h0E, 32'({rx_cfg.weak_signal_suppress, rx_cfg.antenna_switch_on,
            rx_cfg.antenna_switch_dwell}));
        chk("addr ctrl", 32'h2D, 32'({pkt_cfg.addr_field_bytes, pkt_cfg.link_layer_addr,
            pkt_cfg.ctrl_field_bytes}));
        chk("format path", 32'hA, 32'({pkt_cfg.frame_format_sel, pkt_cfg.rx_path_sel}));
        chk("crc spare code", 32'h1000000, 32'({pkt_cfg.crc_on, pkt_cfg.crc_poly}));
        chk("sync upper", 32'h5AC3, 32'(pkt_cfg.sync_upper));
        pll = 1'b0;
        @(negedge clk);
        chk("integral off", 32'h0, 32'(rx_cfg.timing_loop_integral_gain));
        rd(8'h24, 8'h23);
        $display("test decode fields done");
        host_u.acc(1'b1, 8'h27, 8'h10);
        host_u.acc(1'b1, 8'h22, 8'h14);
        for (int k = 0; k < 2; k++)
        begin
            {rxv, cs} = {1'b1, k[0]};
            rssi = 8'h13 + 8'(k);
            @(negedge clk);
            chk("buffer write", k, rxw);
            chk("detect", k, sdet);
        end
        rxv = 1'b0;
        $display("test receive gate done");
        repeat (3) @(negedge clk);
        test_done();
    end
endmodule : rpc_regs_tb_top
bind rpc_regs rpc_regs_sva chk_u (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .rssi_level(rssi_level), .timing_pll_mode(timing_pll_mode), .carrier_sensed(carrier_sensed),
    .rx_byte_valid(rx_byte_valid), .signal_detected(signal_detected), .rx_buffer_write(rx_buffer_write),
    .rx_cfg(rx_cfg), .pkt_cfg(pkt_cfg));
